//--- shared/ccc_pkg.sv
// ccc_pkg: constants shared by the calibration counter block
// assumes: APB register bus with 32-bit data on a 100 MHz pclk
package ccc_pkg;

	// ******************************
	// bus and datapath widths
	// ******************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 24;
	localparam int SRC_N = 8;
	localparam int SRC_IDX_W = 3;
	localparam int SEL_W = 4;
	localparam int IRQ_W = 1;

	// ******************************
	// register byte offsets
	// ******************************
	localparam logic [ADDR_W-1:0] OFF_REF_PROGRAM = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MEAS_READBACK = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_FAST_SELECT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SLOW_SELECT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;

	// ******************************
	// field positions
	// ******************************
	localparam int DONE_POS = 31;
	localparam int CAL1_SEL_LSB = 0;
	localparam int CAL2_SEL_LSB = 8;
	localparam int SLOW_SEL_LSB = 0;
	localparam int IRQ_DONE_POS = 0;

	// fast select code that routes the slow selection through
	localparam logic [SEL_W-1:0] SEL_SLOW_ROUTE = 4'hF;

	// ******************************
	// reset values
	// ******************************
	localparam logic [CNT_W-1:0] RST_COUNT = 24'h00_0000;
	localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ = 1'h0;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

endpackage : ccc_pkg

//--- shared/ccc_sync_if.sv
// ccc_sync_if: synchronised clock source levels, sync stage to user
// assumes: both ends on pclk; only the last two stages are exposed
`timescale 1ns/1ns
interface ccc_sync_if;
	logic [ccc_pkg::SRC_N-1:0] stage_mid; // second flop of each chain
	logic [ccc_pkg::SRC_N-1:0] stage_last; // third flop of each chain
	modport producer (output stage_mid, output stage_last);
	modport consumer (input stage_mid, input stage_last);
endinterface : ccc_sync_if

//--- hw/ccc_sync.sv
// ccc_sync: three-flop synchroniser for every calibration clock source
// assumes: sources are asynchronous to pclk and slower than pclk / 4
`timescale 1ns/1ns
module ccc_sync (
	input wire logic pclk, // register clock
	input wire logic presetn, // async reset, active low
	input wire logic [ccc_pkg::SRC_N-1:0] src_raw, // raw clock sources
	ccc_sync_if.producer sif // synchronised stages out
);
	// ******************************
	// chains
	// ******************************
	logic [ccc_pkg::SRC_N-1:0] first_reg;
	logic [ccc_pkg::SRC_N-1:0] mid_reg;
	logic [ccc_pkg::SRC_N-1:0] last_reg;

	// first stage feeds only the second, never any logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_reg <= '0;
			mid_reg <= '0;
			last_reg <= '0;
		end else begin
			first_reg <= src_raw;
			mid_reg <= first_reg;
			last_reg <= mid_reg;
		end
	end

	assign sif.stage_mid = mid_reg;
	assign sif.stage_last = last_reg;
endmodule : ccc_sync

//--- hw/ccc_edge.sv
// ccc_edge: filtered rising edge detect on one synchronised clock
// assumes: mid and last come from the same synchroniser chain
`timescale 1ns/1ns
module ccc_edge (
	input wire logic pclk, // register clock
	input wire logic presetn, // async reset, active low
	input wire logic mid, // second sync stage
	input wire logic last, // third sync stage
	output logic rise // one-cycle pulse per rising edge
);
	// ******************************
	// level filter
	// ******************************
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;

	// a change counts only once both late stages agree
	always_comb begin
		level_next = level_reg;
		rise_next = 1'b0;
		if (mid == last && mid != level_reg) begin
			level_next = mid;
			rise_next = mid;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
			rise_reg <= rise_next;
		end
	end

	assign rise = rise_reg;

	AST_RISE_AGREE: assert property (@(posedge pclk) disable iff (!presetn)
		rise_reg |-> $past(mid) && $past(last))
		else $error("edge pulse without agreeing sync stages");
endmodule : ccc_edge

//--- hw/ccc_top.sv
// ccc_top: clock calibration counters with APB register access
// assumes: APB3 master on pclk; clock sources are asynchronous pins
//
// Behaviour
// - counter one steps down by one on each rising edge of cal clock one while running.
// - counter two steps up by one on each rising edge of cal clock two while running.
// - once counter one is zero counter two stops and keeps its value for reading.
// - counter one reaching zero sets the done bit in the programming register.
// - software writes the start count and the block loads it as counter one.
// - counter two is readable in its own readback register.
// - either cal clock may be any source, picked by fast and slow select registers.
`timescale 1ns/1ns
module ccc_top (
	input wire logic pclk, // register clock, 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high = write
	input wire logic [ccc_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [ccc_pkg::DATA_W-1:0] pwdata, // apb write data
	output logic [ccc_pkg::DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic [ccc_pkg::SRC_N-1:0] clk_src, // async clock sources
	output logic irq // level interrupt
);
	// ******************************
	// source selection
	// ******************************
	// fast code SEL_SLOW_ROUTE hands the choice to the slow register
	function automatic logic [ccc_pkg::SRC_IDX_W-1:0] src_index(
		input logic [ccc_pkg::SEL_W-1:0] fast_code,
		input logic [ccc_pkg::SEL_W-1:0] slow_code);
		logic [ccc_pkg::SEL_W-1:0] code;
		code = fast_code;
		if (fast_code == ccc_pkg::SEL_SLOW_ROUTE) begin
			code = slow_code;
		end
		return code[ccc_pkg::SRC_IDX_W-1:0];
	endfunction : src_index

	// ******************************
	// state
	// ******************************
	logic [ccc_pkg::CNT_W-1:0] count1_reg, count1_next;
	logic [ccc_pkg::CNT_W-1:0] count2_reg, count2_next;
	logic running_reg, running_next;
	logic done_reg, done_next;
	logic [ccc_pkg::SEL_W-1:0] cal1_sel_reg, cal1_sel_next;
	logic [ccc_pkg::SEL_W-1:0] cal2_sel_reg, cal2_sel_next;
	logic [ccc_pkg::SEL_W-1:0] slow_sel_reg, slow_sel_next;
	logic [ccc_pkg::IRQ_W-1:0] status_reg, status_next;
	logic [ccc_pkg::IRQ_W-1:0] enable_reg, enable_next;
	logic irq_reg, irq_next;
	logic [ccc_pkg::DATA_W-1:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	logic [ccc_pkg::SRC_IDX_W-1:0] idx1, idx2;
	logic edge1, edge2;
	logic setup, access, wr_access;
	logic start, done_evt, mapped;
	logic [ccc_pkg::IRQ_W-1:0] clr_bits;

	ccc_sync_if sif ();

	// ******************************
	// synchronisers and edge filters
	// ******************************
	ccc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.src_raw(clk_src),
		.sif(sif.producer)
	);

	// changing a select mid-run may yield one spurious edge
	assign idx1 = src_index(cal1_sel_reg, slow_sel_reg);
	assign idx2 = src_index(cal2_sel_reg, slow_sel_reg);

	ccc_edge u_edge1 (
		.pclk(pclk),
		.presetn(presetn),
		.mid(sif.stage_mid[idx1]),
		.last(sif.stage_last[idx1]),
		.rise(edge1)
	);

	ccc_edge u_edge2 (
		.pclk(pclk),
		.presetn(presetn),
		.mid(sif.stage_mid[idx2]),
		.last(sif.stage_last[idx2]),
		.rise(edge2)
	);

	// ******************************
	// bus phase decode
	// ******************************
	assign setup = psel && !penable;
	assign access = psel && penable && pready_reg;
	assign wr_access = access && pwrite;
	assign start = wr_access && paddr == ccc_pkg::OFF_REF_PROGRAM;
	assign clr_bits = (wr_access && paddr == ccc_pkg::OFF_IRQ_CLEAR) ?
		pwdata[ccc_pkg::IRQ_W-1:0] : '0;
	assign mapped = paddr == ccc_pkg::OFF_REF_PROGRAM ||
		paddr == ccc_pkg::OFF_MEAS_READBACK ||
		paddr == ccc_pkg::OFF_FAST_SELECT ||
		paddr == ccc_pkg::OFF_SLOW_SELECT ||
		paddr == ccc_pkg::OFF_IRQ_STATUS ||
		paddr == ccc_pkg::OFF_IRQ_CLEAR ||
		paddr == ccc_pkg::OFF_IRQ_ENABLE;

	// ******************************
	// measurement
	// ******************************
	// a start write wins over any edge in the same cycle
	always_comb begin
		count1_next = count1_reg;
		count2_next = count2_reg;
		running_next = running_reg;
		done_next = done_reg;
		done_evt = 1'b0;
		if (start) begin
			count1_next = pwdata[ccc_pkg::CNT_W-1:0];
			count2_next = ccc_pkg::RST_COUNT;
			done_next = 1'b0;
			running_next = 1'b1;
		end else if (running_reg) begin
			if (count1_reg == ccc_pkg::RST_COUNT) begin
				running_next = 1'b0;
				done_next = 1'b1;
				done_evt = 1'b1;
			end else begin
				if (edge1) begin
					count1_next = count1_reg - 24'h00_0001;
				end
				if (edge2) begin
					count2_next = count2_reg + 24'h00_0001;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count1_reg <= ccc_pkg::RST_COUNT;
			count2_reg <= ccc_pkg::RST_COUNT;
			running_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			count1_reg <= count1_next;
			count2_reg <= count2_next;
			running_reg <= running_next;
			done_reg <= done_next;
		end
	end

	// ******************************
	// configuration and interrupt
	// ******************************
	// status set beats a clear landing in the same cycle
	always_comb begin
		cal1_sel_next = cal1_sel_reg;
		cal2_sel_next = cal2_sel_reg;
		slow_sel_next = slow_sel_reg;
		enable_next = enable_reg;
		if (wr_access && paddr == ccc_pkg::OFF_FAST_SELECT) begin
			cal1_sel_next = pwdata[ccc_pkg::CAL1_SEL_LSB +: ccc_pkg::SEL_W];
			cal2_sel_next = pwdata[ccc_pkg::CAL2_SEL_LSB +: ccc_pkg::SEL_W];
		end
		if (wr_access && paddr == ccc_pkg::OFF_SLOW_SELECT) begin
			slow_sel_next = pwdata[ccc_pkg::SLOW_SEL_LSB +: ccc_pkg::SEL_W];
		end
		if (wr_access && paddr == ccc_pkg::OFF_IRQ_ENABLE) begin
			enable_next = pwdata[ccc_pkg::IRQ_W-1:0];
		end
		status_next = status_reg & ~clr_bits;
		status_next[ccc_pkg::IRQ_DONE_POS] =
			status_next[ccc_pkg::IRQ_DONE_POS] | done_evt;
		irq_next = |(status_next & enable_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal1_sel_reg <= ccc_pkg::RST_SEL;
			cal2_sel_reg <= ccc_pkg::RST_SEL;
			slow_sel_reg <= ccc_pkg::RST_SEL;
			status_reg <= ccc_pkg::RST_IRQ;
			enable_reg <= ccc_pkg::RST_IRQ;
			irq_reg <= 1'b0;
		end else begin
			cal1_sel_reg <= cal1_sel_next;
			cal2_sel_reg <= cal2_sel_next;
			slow_sel_reg <= slow_sel_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			irq_reg <= irq_next;
		end
	end

	// ******************************
	// apb answer
	// ******************************
	// read data is captured in setup, so access always ends in one cycle
	always_comb begin
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		if (setup) begin
			pready_next = 1'b1;
			pslverr_next = !mapped;
			prdata_next = ccc_pkg::RST_RDATA;
			if (pwrite) begin
				prdata_next = ccc_pkg::RST_RDATA;
			end else if (paddr == ccc_pkg::OFF_REF_PROGRAM) begin
				prdata_next[ccc_pkg::CNT_W-1:0] = count1_reg;
				prdata_next[ccc_pkg::DONE_POS] = done_reg;
			end else if (paddr == ccc_pkg::OFF_MEAS_READBACK) begin
				prdata_next[ccc_pkg::CNT_W-1:0] = count2_reg;
			end else if (paddr == ccc_pkg::OFF_FAST_SELECT) begin
				prdata_next[ccc_pkg::CAL1_SEL_LSB +: ccc_pkg::SEL_W] =
					cal1_sel_reg;
				prdata_next[ccc_pkg::CAL2_SEL_LSB +: ccc_pkg::SEL_W] =
					cal2_sel_reg;
			end else if (paddr == ccc_pkg::OFF_SLOW_SELECT) begin
				prdata_next[ccc_pkg::SLOW_SEL_LSB +: ccc_pkg::SEL_W] =
					slow_sel_reg;
			end else if (paddr == ccc_pkg::OFF_IRQ_STATUS) begin
				prdata_next[ccc_pkg::IRQ_W-1:0] = status_reg;
			end else if (paddr == ccc_pkg::OFF_IRQ_ENABLE) begin
				prdata_next[ccc_pkg::IRQ_W-1:0] = enable_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= ccc_pkg::RST_RDATA;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	// ******************************
	// assertions
	// ******************************
	AST_COUNT1_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
		running_reg && edge1 && !start && count1_reg != 24'h00_0000
		|=> count1_reg == $past(count1_reg) - 24'h00_0001)
		else $error("counter one did not step down");

	AST_COUNT2_UP: assert property (@(posedge pclk) disable iff (!presetn)
		running_reg && edge2 && !start && count1_reg != 24'h00_0000
		|=> count2_reg == $past(count2_reg) + 24'h00_0001)
		else $error("counter two did not step up");

	AST_COUNT2_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(!running_reg && !start) [*2] |-> $stable(count2_reg))
		else $error("counter two moved after the run ended");

	AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
		running_reg && count1_reg == 24'h00_0000 && !start
		|=> done_reg && !running_reg && status_reg[0])
		else $error("done not raised when counter one hit zero");

	AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> count1_reg == $past(pwdata[23:0]) && running_reg)
		else $error("start value not loaded");

	AST_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == ccc_pkg::OFF_MEAS_READBACK
		|=> pready && prdata[23:0] == $past(count2_reg))
		else $error("readback does not show counter two");

	AST_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && paddr == ccc_pkg::OFF_FAST_SELECT && pwdata[3:0] != 4'hF
		|=> idx1 == $past(pwdata[2:0]))
		else $error("cal clock one not routed to chosen source");

	AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> !done_reg && count2_reg == 24'h00_0000)
		else $error("start did not clear done and counter two");

	// irq is registered from the next values, so it tracks the level exactly
	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (status_reg[0] && enable_reg[0]))
		else $error("interrupt low while enabled status set");

	COV_DONE: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(done_reg) && count2_reg != 24'h00_0000);
	COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(irq));
	COV_RESTART: cover property (@(posedge pclk) disable iff (!presetn)
		start && running_reg);
	COV_SLOW_ROUTE: cover property (@(posedge pclk) disable iff (!presetn)
		cal2_sel_reg == 4'hF && edge2 && running_reg);
endmodule : ccc_top

//--- verif/ccc_tb_top.sv
// ccc_tb_top: self-checking bench for the calibration counter block
// assumes: ccc_pkg compiled first; the bench drives apb and sources itself
`timescale 1ns/1ns
`define CHK(g, e) check_val(g, e)
module ccc_tb_top;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ccc_pkg::ADDR_W-1:0] paddr;
	logic [ccc_pkg::DATA_W-1:0] pwdata;
	logic [ccc_pkg::DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [ccc_pkg::SRC_N-1:0] clk_src;
	logic irq;
	logic [31:0] rd;
	logic er;
	int n_errors;
	int check_count;
	int cyc;
	int seed_ret;
	int i, it, p, n, k, m, s1, s2, c1, c2, en, sl;

	ccc_top dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.clk_src(clk_src),
		.irq(irq)
	);

	// ****************************************
	// clock and hang guard
	// ****************************************
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// ceiling well above the few thousand cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_val

	// expected programming register view: done flag over live count one
	function automatic logic [31:0] exp_ref(input int cnt, input bit done);
		return {done, 7'h00, 24'(cnt)};
	endfunction : exp_ref

	// one whole apb transfer; request held until pready is seen high at a
	// rising edge, answer taken there; a hang is left to the cycle ceiling
	task automatic apb(input logic wr, input logic [ccc_pkg::ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [ccc_pkg::ADDR_W-1:0] a,
		input logic [31:0] exp, input logic ee);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, exp);
		`CHK({31'h0000_0000, er}, {31'h0000_0000, ee});
	endtask : rchk

	// one source pulse, kept wider than four pclk periods each phase
	task automatic pulse(input int b);
		@(posedge pclk);
		clk_src[b] <= 1'b1;
		repeat (6) @(posedge pclk);
		clk_src[b] <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : pulse

	task automatic irq_chk(input logic exp);
		@(negedge pclk);
		`CHK({31'h0000_0000, irq}, {31'h0000_0000, exp});
	endtask : irq_chk

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		clk_src = 8'h00;
		seed_ret = $urandom(43);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// every register reads zero out of reset, clear included
		for (i = 0; i < 7; i++) begin
			rchk(8'(i * 4), 32'h0000_0000, 1'b0);
		end
		irq_chk(1'b0);
		// unmapped places answer with an error
		rchk(8'h1C, 32'h0000_0000, 1'b1);
		apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		`CHK({31'h0000_0000, er}, 32'h0000_0001);
		// random runs through every way of picking the two clocks
		for (it = 0; it < 6; it++) begin
			n = 1 + $urandom % 6;
			k = $urandom % 4;
			s1 = $urandom % 8;
			s2 = (s1 + 1 + $urandom % 7) % 8;
			// alias codes only below 7, since 8 + 7 is the slow route code
			c1 = (s1 < 7 && it % 2 == 1) ? 8 + s1 : s1;
			c2 = (s2 < 7 && it % 2 == 0) ? 8 + s2 : s2;
			sl = (it % 3 == 1) ? s2 : s1;
			// slow route code hands one clock to the slow register
			if (it % 3 == 2) begin
				c1 = 15;
			end else if (it % 3 == 1) begin
				c2 = 15;
			end
			en = (it % 2 == 0) ? 1 : 0;
			apb(1'b1, ccc_pkg::OFF_SLOW_SELECT, 32'(sl));
			apb(1'b1, ccc_pkg::OFF_FAST_SELECT, 32'(c1 | (c2 << 8)));
			rchk(ccc_pkg::OFF_FAST_SELECT, 32'(c1 | (c2 << 8)), 1'b0);
			rchk(ccc_pkg::OFF_SLOW_SELECT, 32'(sl), 1'b0);
			apb(1'b1, ccc_pkg::OFF_IRQ_ENABLE, 32'(en));
			apb(1'b1, ccc_pkg::OFF_REF_PROGRAM, 32'(n));
			rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(n, 0), 1'b0);
			rchk(ccc_pkg::OFF_MEAS_READBACK, 32'h0000_0000, 1'b0);
			m = n / 2;
			for (p = 0; p < n; p++) begin
				if (p == m && m > 0) begin
					repeat (10) @(posedge pclk);
					rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(n - m, 0), 1'b0);
					rchk(ccc_pkg::OFF_MEAS_READBACK, 32'(k * m), 1'b0);
				end
				repeat (k) pulse(s2);
				pulse(s1);
			end
			repeat (10) @(posedge pclk);
			rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(0, 1), 1'b0);
			// edges after done must leave both counts alone
			pulse(s2);
			pulse(s1);
			repeat (10) @(posedge pclk);
			apb(1'b1, ccc_pkg::OFF_MEAS_READBACK, 32'h00FF_FFFF);
			rchk(ccc_pkg::OFF_MEAS_READBACK, 32'(n * k), 1'b0);
			rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(0, 1), 1'b0);
			rchk(ccc_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 1'b0);
			irq_chk(en[0]);
			apb(1'b1, ccc_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
			rchk(ccc_pkg::OFF_IRQ_STATUS, 32'h0000_0000, 1'b0);
			irq_chk(1'b0);
		end
		// restart in mid-run drops the partial counts
		apb(1'b1, ccc_pkg::OFF_REF_PROGRAM, 32'h0000_0005);
		pulse(s2);
		pulse(s1);
		apb(1'b1, ccc_pkg::OFF_REF_PROGRAM, 32'h0000_0003);
		rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(3, 0), 1'b0);
		rchk(ccc_pkg::OFF_MEAS_READBACK, 32'h0000_0000, 1'b0);
		// a start of zero finishes at once with nothing counted
		apb(1'b1, ccc_pkg::OFF_REF_PROGRAM, 32'h0000_0000);
		repeat (4) @(posedge pclk);
		rchk(ccc_pkg::OFF_REF_PROGRAM, exp_ref(0, 1), 1'b0);
		rchk(ccc_pkg::OFF_MEAS_READBACK, 32'h0000_0000, 1'b0);
		// reset in mid-run brings counts, selects and status back to zero
		apb(1'b1, ccc_pkg::OFF_REF_PROGRAM, 32'h0000_0004);
		pulse(s1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ccc_pkg::OFF_REF_PROGRAM, 32'h0000_0000, 1'b0);
		rchk(ccc_pkg::OFF_MEAS_READBACK, 32'h0000_0000, 1'b0);
		rchk(ccc_pkg::OFF_IRQ_STATUS, 32'h0000_0000, 1'b0);
		rchk(ccc_pkg::OFF_FAST_SELECT, 32'h0000_0000, 1'b0);
		irq_chk(1'b0);
		give_verdict();
	end
endmodule : ccc_tb_top
